// ### core/pss_consts.svh
`ifndef PSS_CONSTS_SVH
`define PSS_CONSTS_SVH

// system clock rate
`define PSS_CLK_MHZ 200
// fixed upper five bits of the 7-bit bus address
`define PSS_ADDR_BASE 5'h17
// command bytes
`define PSS_CMD_RESET 8'h11
`define PSS_CMD_BLOCK 8'h20
`define PSS_CMD_START 8'h21
// number of data bytes in a read frame
`define PSS_RD_BYTES 3'h6
// conversion and sleep times in ms
`define PSS_T_FIRST_MS 16
`define PSS_T_NEXT_MS 5
`define PSS_T_WAKE_MS 1.5
// the same times in clock cycles
`define PSS_T_FIRST_CYC ($rtoi(`PSS_T_FIRST_MS * 1000.0 * `PSS_CLK_MHZ))
`define PSS_T_NEXT_CYC ($rtoi(`PSS_T_NEXT_MS * 1000.0 * `PSS_CLK_MHZ))
`define PSS_T_WAKE_CYC ($rtoi(`PSS_T_WAKE_MS * 1000.0 * `PSS_CLK_MHZ))
// host bus clock rate and its half period in cycles
`define PSS_SCL_KHZ 100
`define PSS_HALF_CYC ((`PSS_CLK_MHZ * 1000) / (2 * `PSS_SCL_KHZ))
// host register offsets
`define PSS_REG_CMD 8'h00
`define PSS_REG_STAT 8'h04
// host command register fields
`define PSS_CMD_START_BIT 8
`define PSS_CMD_STOP_BIT 9
`define PSS_CMD_READ_BIT 10
`define PSS_CMD_NACK_BIT 11
`define PSS_CMD_FLUSH_BIT 12
// host status register fields
`define PSS_STAT_BUSY_BIT 0
`define PSS_STAT_ACK_BIT 1

`endif

// ### core/pss_pkg.sv
package pss_pkg;
	// read mode chosen by the last mode command
	typedef enum logic [1:0] {MODE_NONE, MODE_BLOCK, MODE_START} pss_mode_e;
	// device byte-level states
	typedef enum logic [2:0] {D_IDLE, D_ADDR, D_ACK_ADDR, D_WR, D_ACK_WR,
		D_RD, D_ACK_RD} pss_dst_e;
	// host bit-level states
	typedef enum logic [3:0] {H_IDLE, H_START_A, H_START_W, H_START_B, H_LOW,
		H_HIGH, H_STOP_A, H_STOP_B, H_STOP_C} pss_hst_e;
endpackage

// ### core/pss_i2c_if.sv
`timescale 1ns/1ps
interface pss_i2c_if;
	// open-drain drives of each end: enable high pulls the wire to o
	logic dev_scl_o;
	logic dev_scl_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic host_scl_o;
	logic host_scl_oe;
	logic host_sda_o;
	logic host_sda_oe;
	// resolved wire levels, pulled up when nobody drives low
	logic scl;
	logic sda;
	assign scl = ~((dev_scl_oe & ~dev_scl_o) | (host_scl_oe & ~host_scl_o));
	assign sda = ~((dev_sda_oe & ~dev_sda_o) | (host_sda_oe & ~host_sda_o));
	modport device (input scl, input sda, output dev_scl_o, output dev_scl_oe,
		output dev_sda_o, output dev_sda_oe);
	modport host (input scl, input sda, output host_scl_o,
		output host_scl_oe, output host_sda_o, output host_sda_oe);
endinterface

// ### core/pss_host.sv
`timescale 1ns/1ps
`include "pss_consts.svh"
module pss_host #(
	parameter int HALF_CYC = `PSS_HALF_CYC
)(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// i2c link
	pss_i2c_if.host bus
);
	localparam logic [15:0] HALF = 16'(HALF_CYC);
	localparam logic [15:0] MID = 16'(HALF_CYC / 2);
	pss_pkg::pss_hst_e state_q; // bit engine state
	logic [15:0] tmr_q; // phase timer
	logic [8:0] bits_q; // bits still to send, msb first
	logic [8:0] rx_q; // sampled line bits, last one is the ack slot
	logic [3:0] cnt_q; // bits done in this byte
	logic stop_q; // stop after this byte
	logic scl_oe_q;
	logic sda_oe_q;
	logic [1:0] scl_ff_q; // line synchronisers
	logic [1:0] sda_ff_q;
	logic scl_s;
	logic sda_s;
	logic acc;
	logic go;
	logic mapped;

	// sync the wires before any logic looks at them
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			scl_ff_q <= 2'h3;
			sda_ff_q <= 2'h3;
		end
		else
		begin
			scl_ff_q <= {scl_ff_q[0], bus.scl};
			sda_ff_q <= {sda_ff_q[0], bus.sda};
		end
	end
	assign scl_s = scl_ff_q[1];
	assign sda_s = sda_ff_q[1];

	// zero-wait apb: read data latched in setup, answered in access
	assign acc = psel & penable;
	assign mapped = (paddr == `PSS_REG_CMD) | (paddr == `PSS_REG_STAT);
	assign pready = 1'b1;
	assign pslverr = acc & ~mapped;
	// a command written while busy is dropped, software polls busy first
	assign go = acc & pwrite & (paddr == `PSS_REG_CMD)
		& (state_q == pss_pkg::H_IDLE);

	// status readback
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0;
		else if (psel & ~penable & ~pwrite & (paddr == `PSS_REG_STAT))
			prdata <= {16'h0, rx_q[8:1], 6'h0, ~rx_q[0],
				state_q != pss_pkg::H_IDLE};
		else if (psel & ~penable)
			prdata <= 32'h0;
	end

	// bit engine: scl from a divider, waits while the slave stretches
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_q <= pss_pkg::H_IDLE;
			tmr_q <= 16'h0;
			bits_q <= 9'h1FF;
			rx_q <= 9'h1FF;
			cnt_q <= 4'h0;
			stop_q <= 1'b0;
			scl_oe_q <= 1'b0;
			sda_oe_q <= 1'b0;
		end
		else
		begin
			case (state_q)
				pss_pkg::H_IDLE:
					if (go)
					begin
						// flush clocks nine released bits, a read releases data
						// and answers ack or nack, a write sends the byte
						if (pwdata[`PSS_CMD_FLUSH_BIT])
							bits_q <= 9'h1FF;
						else if (pwdata[`PSS_CMD_READ_BIT])
							bits_q <= {8'hFF, pwdata[`PSS_CMD_NACK_BIT]};
						else
							bits_q <= {pwdata[7:0], 1'b1};
						stop_q <= pwdata[`PSS_CMD_STOP_BIT];
						cnt_q <= 4'h0;
						tmr_q <= HALF;
						if (pwdata[`PSS_CMD_START_BIT] & ~pwdata[`PSS_CMD_FLUSH_BIT])
						begin
							sda_oe_q <= 1'b0;
							state_q <= pss_pkg::H_START_A;
						end
						else
						begin
							scl_oe_q <= 1'b1;
							state_q <= pss_pkg::H_LOW;
						end
					end
				pss_pkg::H_START_A:
					// data released first so a repeated start is no stop
					if (tmr_q == 16'h0)
					begin
						scl_oe_q <= 1'b0;
						tmr_q <= HALF;
						state_q <= pss_pkg::H_START_W;
					end
					else
						tmr_q <= tmr_q - 16'h1;
				pss_pkg::H_START_W:
					if (scl_s)
					begin
						if (tmr_q == 16'h0)
						begin
							sda_oe_q <= 1'b1;
							tmr_q <= HALF;
							state_q <= pss_pkg::H_START_B;
						end
						else
							tmr_q <= tmr_q - 16'h1;
					end
				pss_pkg::H_START_B:
					if (tmr_q == 16'h0)
					begin
						scl_oe_q <= 1'b1;
						tmr_q <= HALF;
						state_q <= pss_pkg::H_LOW;
					end
					else
						tmr_q <= tmr_q - 16'h1;
				pss_pkg::H_LOW:
				begin
					// data changes mid low phase, well away from both edges
					if (tmr_q == MID)
						sda_oe_q <= ~bits_q[8];
					if (tmr_q == 16'h0)
					begin
						scl_oe_q <= 1'b0;
						tmr_q <= HALF;
						state_q <= pss_pkg::H_HIGH;
					end
					else
						tmr_q <= tmr_q - 16'h1;
				end
				pss_pkg::H_HIGH:
					// timer holds while the slave keeps scl low
					if (scl_s)
					begin
						if (tmr_q == 16'h0)
						begin
							rx_q <= {rx_q[7:0], sda_s};
							bits_q <= {bits_q[7:0], 1'b1};
							cnt_q <= cnt_q + 4'h1;
							scl_oe_q <= 1'b1;
							tmr_q <= HALF;
							if (cnt_q != 4'h8)
								state_q <= pss_pkg::H_LOW;
							else if (stop_q)
								state_q <= pss_pkg::H_STOP_A;
							else
								state_q <= pss_pkg::H_IDLE;
						end
						else
							tmr_q <= tmr_q - 16'h1;
					end
				pss_pkg::H_STOP_A:
				begin
					if (tmr_q == MID)
						sda_oe_q <= 1'b1;
					if (tmr_q == 16'h0)
					begin
						scl_oe_q <= 1'b0;
						tmr_q <= HALF;
						state_q <= pss_pkg::H_STOP_B;
					end
					else
						tmr_q <= tmr_q - 16'h1;
				end
				pss_pkg::H_STOP_B:
					if (scl_s)
					begin
						if (tmr_q == 16'h0)
						begin
							sda_oe_q <= 1'b0;
							tmr_q <= HALF;
							state_q <= pss_pkg::H_STOP_C;
						end
						else
							tmr_q <= tmr_q - 16'h1;
					end
				pss_pkg::H_STOP_C:
					if (tmr_q == 16'h0)
						state_q <= pss_pkg::H_IDLE;
					else
						tmr_q <= tmr_q - 16'h1;
				default:
					state_q <= pss_pkg::H_IDLE;
			endcase
		end
	end

	assign bus.host_scl_o = 1'b0;
	assign bus.host_sda_o = 1'b0;
	assign bus.host_scl_oe = scl_oe_q;
	assign bus.host_sda_oe = sda_oe_q;
endmodule

// ### core/pss_dev.sv
// Local design decisions: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`include "pss_consts.svh"
// What this block does
// - answer at address 10111 plus strap levels
// - first strap sets bit 0, second bit 1
// - reset command clears all operating state, but a conversion ending in the same cycle still sets the new-data flag
// - blocking command selects convert-on-read mode
// - each read addressing converts afresh
// - hold scl low until conversion data ready
// - first conversion long, later short if prompt
// - no request within window means sleep again
// - one to six bytes, stop driving on nack
// - byte one pressure 7:1 plus flag, then 15:8
// - then temperature and supply, low byte first
// - values pass as signed two's complement
// - start command converts at once, bus free
// - finished result read with no stretch
// - read during conversion stretched until done
// - flag set on first read of new data only
// - host resends start command for new data
// - stretch only for pending conversions
// - non-stretching host waits, slow clock
// - host flushes bus with nine clocks
// - unfinished read shifts out then releases
// - host treats flag position as zero
module pss_dev #(
	parameter int T_FIRST_CYC = `PSS_T_FIRST_CYC,
	parameter int T_NEXT_CYC = `PSS_T_NEXT_CYC,
	parameter int T_WAKE_CYC = `PSS_T_WAKE_CYC
)(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// i2c link
	pss_i2c_if.device bus,
	// address straps
	input wire logic addr_strap_low,
	input wire logic addr_strap_high,
	// raw values from the converter, signed
	input wire logic signed [15:0] pressure_bits,
	input wire logic signed [15:0] temperature_bits,
	input wire logic signed [15:0] supply_voltage_bits,
	// state for the user side
	output pss_pkg::pss_mode_e read_mode,
	output logic conv_busy,
	output logic new_data_flag,
	output logic asleep
);
	pss_pkg::pss_dst_e state_q; // byte-level state
	pss_pkg::pss_mode_e mode_q; // selected read mode
	logic [1:0] scl_ff_q; // line and strap synchronisers
	logic [1:0] sda_ff_q;
	logic [1:0] s0_ff_q;
	logic [1:0] s1_ff_q;
	logic scl_prev_q;
	logic sda_prev_q;
	logic scl_s;
	logic sda_s;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	logic [6:0] my_addr; // own 7-bit address
	logic [3:0] cnt_q; // bits taken or sent in this byte
	logic [7:0] shreg_q; // incoming byte
	logic [7:0] tx_q; // outgoing byte
	logic [2:0] idx_q; // data byte index
	logic rw_q; // read direction of this frame
	logic ack_in_q; // host acked the last data byte
	logic sda_oe_q;
	logic hold_q; // scl stretch
	logic cmd_stb_q; // one-cycle pulse with a command byte
	logic [7:0] cmd_q;
	logic rd_req_q; // one-cycle pulse on read addressing
	logic rd_first_q; // one-cycle pulse when byte one is loaded
	logic busy_q;
	logic [23:0] conv_cnt_q; // conversion countdown
	logic awake_q; // inside the fast window
	logic [23:0] wake_cnt_q; // window countdown
	logic signed [15:0] res_p_q; // latched results
	logic signed [15:0] res_t_q;
	logic signed [15:0] res_v_q;
	logic new_q;
	logic [7:0] byte_first; // byte one as it would be loaded now
	logic [7:0] byte_next; // byte that follows the current one

	// data byte mux, flag in the last bit of byte one
	function automatic logic [7:0] byte_sel(input logic [2:0] i);
		case (i)
			3'h0: byte_sel = {res_p_q[7:1], new_q};
			3'h1: byte_sel = res_p_q[15:8];
			3'h2: byte_sel = res_t_q[7:0];
			3'h3: byte_sel = res_t_q[15:8];
			3'h4: byte_sel = res_v_q[7:0];
			3'h5: byte_sel = res_v_q[15:8];
			default: byte_sel = 8'hFF;
		endcase
	endfunction

	// outgoing bytes picked in a process so result updates are seen
	always_comb
	begin
		byte_first = byte_sel(3'h0);
		byte_next = byte_sel(idx_q + 3'h1);
	end

	// two flops on every pin before use
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			scl_ff_q <= 2'h3;
			sda_ff_q <= 2'h3;
			s0_ff_q <= 2'h0;
			s1_ff_q <= 2'h0;
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
		end
		else
		begin
			scl_ff_q <= {scl_ff_q[0], bus.scl};
			sda_ff_q <= {sda_ff_q[0], bus.sda};
			s0_ff_q <= {s0_ff_q[0], addr_strap_low};
			s1_ff_q <= {s1_ff_q[0], addr_strap_high};
			scl_prev_q <= scl_ff_q[1];
			sda_prev_q <= sda_ff_q[1];
		end
	end
	assign scl_s = scl_ff_q[1];
	assign sda_s = sda_ff_q[1];
	assign scl_rise = scl_s & ~scl_prev_q;
	assign scl_fall = ~scl_s & scl_prev_q;
	assign start_det = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
	assign stop_det = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
	assign my_addr = {`PSS_ADDR_BASE, s1_ff_q[1], s0_ff_q[1]};

	// byte engine: sample on rising scl, drive on falling scl
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_q <= pss_pkg::D_IDLE;
			cnt_q <= 4'h0;
			shreg_q <= 8'h0;
			tx_q <= 8'hFF;
			idx_q <= 3'h0;
			rw_q <= 1'b0;
			ack_in_q <= 1'b0;
			sda_oe_q <= 1'b0;
			hold_q <= 1'b0;
			cmd_stb_q <= 1'b0;
			cmd_q <= 8'h0;
			rd_req_q <= 1'b0;
			rd_first_q <= 1'b0;
		end
		else
		begin
			cmd_stb_q <= 1'b0;
			rd_req_q <= 1'b0;
			rd_first_q <= 1'b0;
			// let scl go once the result is latched; the pulse guard covers
			// the cycle before the conversion shows busy
			if (hold_q & ~busy_q & ~rd_req_q)
				hold_q <= 1'b0;
			if (start_det)
			begin
				state_q <= pss_pkg::D_ADDR;
				cnt_q <= 4'h0;
				sda_oe_q <= 1'b0;
			end
			else if (stop_det)
			begin
				state_q <= pss_pkg::D_IDLE;
				sda_oe_q <= 1'b0;
			end
			else
			begin
				case (state_q)
					pss_pkg::D_IDLE:
						sda_oe_q <= 1'b0;
					pss_pkg::D_ADDR:
						if (scl_rise)
						begin
							shreg_q <= {shreg_q[6:0], sda_s};
							cnt_q <= cnt_q + 4'h1;
						end
						else if (scl_fall && cnt_q == 4'h8)
						begin
							if (shreg_q[7:1] == my_addr)
							begin
								sda_oe_q <= 1'b1;
								rw_q <= shreg_q[0];
								state_q <= pss_pkg::D_ACK_ADDR;
								if (shreg_q[0])
								begin
									rd_req_q <= 1'b1;
									// stretch only when a conversion is due
									if (mode_q == pss_pkg::MODE_BLOCK || busy_q)
										hold_q <= 1'b1;
								end
							end
							else
								state_q <= pss_pkg::D_IDLE;
						end
					pss_pkg::D_ACK_ADDR:
						if (scl_fall)
						begin
							cnt_q <= 4'h0;
							if (rw_q)
							begin
								tx_q <= byte_first;
								sda_oe_q <= ~byte_first[7];
								cnt_q <= 4'h1;
								idx_q <= 3'h0;
								rd_first_q <= 1'b1;
								state_q <= pss_pkg::D_RD;
							end
							else
							begin
								sda_oe_q <= 1'b0;
								state_q <= pss_pkg::D_WR;
							end
						end
					pss_pkg::D_WR:
						if (scl_rise)
						begin
							shreg_q <= {shreg_q[6:0], sda_s};
							cnt_q <= cnt_q + 4'h1;
						end
						else if (scl_fall && cnt_q == 4'h8)
						begin
							sda_oe_q <= 1'b1;
							cmd_stb_q <= 1'b1;
							cmd_q <= shreg_q;
							state_q <= pss_pkg::D_ACK_WR;
						end
					pss_pkg::D_ACK_WR:
						if (scl_fall)
						begin
							sda_oe_q <= 1'b0;
							cnt_q <= 4'h0;
							state_q <= pss_pkg::D_WR;
						end
					pss_pkg::D_RD:
						// keeps shifting even without a start, so a flush
						// drains the byte and then frees the data line
						if (scl_fall)
						begin
							if (cnt_q == 4'h8)
							begin
								sda_oe_q <= 1'b0;
								state_q <= pss_pkg::D_ACK_RD;
							end
							else
							begin
								tx_q <= {tx_q[6:0], 1'b1};
								sda_oe_q <= ~tx_q[6];
								cnt_q <= cnt_q + 4'h1;
							end
						end
					pss_pkg::D_ACK_RD:
						if (scl_rise)
							ack_in_q <= ~sda_s;
						else if (scl_fall)
						begin
							if (ack_in_q && idx_q < `PSS_RD_BYTES - 3'h1)
							begin
								idx_q <= idx_q + 3'h1;
								tx_q <= byte_next;
								sda_oe_q <= ~byte_next[7];
								cnt_q <= 4'h1;
								state_q <= pss_pkg::D_RD;
							end
							else
							begin
								sda_oe_q <= 1'b0;
								state_q <= pss_pkg::D_IDLE;
							end
						end
					default:
						state_q <= pss_pkg::D_IDLE;
				endcase
			end
		end
	end

	// read mode register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			mode_q <= pss_pkg::MODE_NONE;
		else if (cmd_stb_q)
		begin
			case (cmd_q)
				`PSS_CMD_RESET: mode_q <= pss_pkg::MODE_NONE;
				`PSS_CMD_BLOCK: mode_q <= pss_pkg::MODE_BLOCK;
				`PSS_CMD_START: mode_q <= pss_pkg::MODE_START;
				default: mode_q <= mode_q;
			endcase
		end
	end

	// conversion engine, results kept signed as delivered
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			busy_q <= 1'b0;
			conv_cnt_q <= 24'h0;
			res_p_q <= 16'sh0;
			res_t_q <= 16'sh0;
			res_v_q <= 16'sh0;
		end
		else if (cmd_stb_q && cmd_q == `PSS_CMD_RESET)
		begin
			busy_q <= 1'b0;
			res_p_q <= 16'sh0;
			res_t_q <= 16'sh0;
			res_v_q <= 16'sh0;
		end
		else if (cmd_stb_q && cmd_q == `PSS_CMD_START)
		begin
			// each started conversion takes the long time
			busy_q <= 1'b1;
			conv_cnt_q <= 24'(T_FIRST_CYC);
		end
		else if (rd_req_q && mode_q == pss_pkg::MODE_BLOCK)
		begin
			busy_q <= 1'b1;
			conv_cnt_q <= awake_q ? 24'(T_NEXT_CYC) : 24'(T_FIRST_CYC);
		end
		else if (busy_q)
		begin
			if (conv_cnt_q <= 24'h1)
			begin
				busy_q <= 1'b0;
				res_p_q <= pressure_bits;
				res_t_q <= temperature_bits;
				res_v_q <= supply_voltage_bits;
			end
			else
				conv_cnt_q <= conv_cnt_q - 24'h1;
		end
	end

	// fast window after each release; the converter sleeps when it lapses
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			awake_q <= 1'b0;
			wake_cnt_q <= 24'h0;
		end
		else if (cmd_stb_q && cmd_q == `PSS_CMD_RESET)
			awake_q <= 1'b0;
		else if (busy_q && conv_cnt_q <= 24'h1)
		begin
			awake_q <= 1'b1;
			wake_cnt_q <= 24'(T_WAKE_CYC);
		end
		else if (awake_q && !busy_q && !rd_req_q)
		begin
			if (wake_cnt_q == 24'h0)
				awake_q <= 1'b0;
			else
				wake_cnt_q <= wake_cnt_q - 24'h1;
		end
	end

	// new-data flag: a finishing conversion beats a clearing read
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			new_q <= 1'b0;
		else if (busy_q && conv_cnt_q <= 24'h1)
			new_q <= 1'b1;
		else if (rd_first_q || (cmd_stb_q && cmd_q == `PSS_CMD_RESET))
			new_q <= 1'b0;
	end

	assign bus.dev_scl_o = 1'b0;
	assign bus.dev_sda_o = 1'b0;
	assign bus.dev_scl_oe = hold_q;
	assign bus.dev_sda_oe = sda_oe_q;
	assign read_mode = mode_q;
	assign conv_busy = busy_q;
	assign new_data_flag = new_q;
	assign asleep = ~awake_q;
endmodule

// ### tb/pss_dev_chk.sv
`timescale 1ns/1ps
// watches the link wires and the sensor state beside the interface
module pss_chk #(
	parameter int T_FIRST_CYC = 400,
	parameter int T_NEXT_CYC = 150,
	parameter int T_WAKE_CYC = 100
)(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// link wires
	input wire logic scl,
	input wire logic dev_scl_oe,
	input wire logic dev_sda_oe,
	// sensor state
	input wire pss_pkg::pss_mode_e read_mode,
	input wire logic conv_busy,
	input wire logic new_data_flag,
	input wire logic asleep
);
	int busy_q; // cycles the running conversion has taken
	int idle_q; // cycles since the last conversion ended

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// conversion length, cleared between conversions
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			busy_q <= 0;
		else if (conv_busy)
			busy_q <= busy_q + 1;
		else
			busy_q <= 0;
	end

	// idle time, saturated so a long quiet spell never wraps
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			idle_q <= 0;
		else if (conv_busy)
			idle_q <= 0;
		else if (idle_q < T_WAKE_CYC + 10)
			idle_q <= idle_q + 1;
	end

	a_reset_quiet: assert property ($rose(presetn) |-> !dev_scl_oe &&
		!dev_sda_oe && !conv_busy && asleep &&
		read_mode == pss_pkg::MODE_NONE) else $error("state after reset");
	a_stretch_cause: assert property ($rose(dev_scl_oe) |->
		##[0:2] conv_busy) else $error("stretch without conversion");
	a_stretch_holds: assert property (dev_scl_oe && conv_busy ##1
		conv_busy |-> dev_scl_oe) else $error("clock freed too soon");
	a_stretch_ends: assert property ($fell(conv_busy) |->
		##[0:3] !dev_scl_oe) else $error("clock held after conversion");
	a_conv_len: assert property ($fell(conv_busy) |->
		(busy_q >= T_FIRST_CYC - 3 && busy_q <= T_FIRST_CYC + 3) ||
		(busy_q >= T_NEXT_CYC - 3 && busy_q <= T_NEXT_CYC + 3))
		else $error("conversion length wrong");
	a_flag_on_done: assert property ($fell(conv_busy) |->
		##[0:2] new_data_flag) else $error("new data flag not set");
	a_wake_window: assert property ($fell(conv_busy) &&
		read_mode == pss_pkg::MODE_BLOCK |-> ##[0:3] !asleep)
		else $error("window not opened");
	a_sleep_later: assert property (idle_q == T_WAKE_CYC + 5 |->
		asleep) else $error("no sleep after window");
	a_sda_on_low: assert property ($changed(dev_sda_oe) |->
		!scl) else $error("data changed while clock high");
endmodule

// ### tb/tb_top.sv
`timescale 1ns/1ps
`include "pss_consts.svh"
// one compare, counted, reported at once on a mismatch
`define CHK(nm, ex, gt) \
	begin \
		tests_run++; \
		if ((gt) !== (ex)) \
		begin \
			miscompares++; \
			$display("ERROR %s expected %0h seen %0h", nm, ex, gt); \
		end \
	end
module tb_top;
	// short conversion times keep the run brief
	localparam int T_FIRST = 4000;
	localparam int T_NEXT = 1500;
	localparam int T_WAKE = 2500;
	localparam int LONG = (T_FIRST + T_NEXT) / 2;
	// host command flags: start, stop, read, nack, flush
	localparam logic [4:0] S = 5'h01, P = 5'h02, R = 5'h04;
	localparam logic [4:0] N = 5'h08, F = 5'h10;
	// clock, reset and apb
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0, prdata;
	logic pready, pslverr;
	// sensor side
	logic addr_strap_low = 1'b0, addr_strap_high = 1'b0;
	logic signed [15:0] pres = 16'h0, temp = 16'h0, supp = 16'h0;
	pss_pkg::pss_mode_e read_mode;
	logic conv_busy, new_data_flag, asleep;
	// bench state
	int miscompares = 0, tests_run = 0, seed = 38889;
	int st_cnt = 0, d0, d;
	logic [31:0] stat, errq;
	logic [7:0] got [6];
	logic [6:0] ad;

	pss_i2c_if pss_i2c_if_inst ();
	pss_host #(.HALF_CYC(20)) pss_host_inst (.pclk, .presetn, .paddr,
		.psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
		.bus(pss_i2c_if_inst));
	pss_dev #(.T_FIRST_CYC(T_FIRST), .T_NEXT_CYC(T_NEXT),
		.T_WAKE_CYC(T_WAKE)) pss_dev_inst (.pclk, .presetn,
		.bus(pss_i2c_if_inst), .addr_strap_low, .addr_strap_high,
		.pressure_bits(pres), .temperature_bits(temp),
		.supply_voltage_bits(supp), .read_mode, .conv_busy,
		.new_data_flag, .asleep);
	pss_chk #(.T_FIRST_CYC(T_FIRST), .T_NEXT_CYC(T_NEXT),
		.T_WAKE_CYC(T_WAKE)) pss_chk_inst (.pclk, .presetn,
		.scl(pss_i2c_if_inst.scl), .dev_scl_oe(pss_i2c_if_inst.dev_scl_oe),
		.dev_sda_oe(pss_i2c_if_inst.dev_sda_oe), .read_mode, .conv_busy,
		.new_data_flag, .asleep);

	// 200 MHz
	always #2.5 pclk = ~pclk;

	// stretch cycles counted
	always @(posedge pclk)
	begin
		if (pss_i2c_if_inst.dev_scl_oe === 1'b1)
			st_cnt <= st_cnt + 1;
	end

	// one apb transfer, held until pready is seen high
	task automatic apb(input logic [7:0] a, input logic w,
		input logic [31:0] wd, output logic [31:0] rd);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		// answer taken at the very edge that ends the access
		rd = prdata;
		errq = {31'h0, pslverr};
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// one host byte operation, then poll until the engine is idle
	task automatic op(input logic [4:0] f, input logic [7:0] b);
		apb(`PSS_REG_CMD, 1'b1, {19'h0, f, b}, stat);
		do apb(`PSS_REG_STAT, 1'b0, 32'h0, stat); while (stat[0] !== 1'b0);
	endtask

	// command write frame
	task automatic wr(input logic [7:0] c);
		op(S, {ad, 1'b0});
		`CHK("write ack", 1'b1, stat[1]);
		op(P, c);
	endtask

	// read frame of n bytes, last one refused; stretch cycles into d
	task automatic rd(input int n);
		d0 = st_cnt;
		op(S, {ad, 1'b1});
		`CHK("read ack", 1'b1, stat[1]);
		for (int i = 0; i < n; i++)
		begin
			op(R | ((i == n - 1) ? (N | P) : 5'h00), 8'hFF);
			got[i] = stat[15:8];
		end
		d = st_cnt - d0;
	endtask

	// expected frame worked out from the converter inputs
	task automatic cmp(input int n, input logic f);
		logic [7:0] e [6];
		e = '{{pres[7:1], f}, pres[15:8], temp[7:0], temp[15:8],
			supp[7:0], supp[15:8]};
		for (int i = 0; i < n; i++) `CHK("data", e[i], got[i]);
	endtask

	// fresh converter values
	task automatic rnd;
		pres <= 16'($random(seed));
		temp <= 16'($random(seed));
		supp <= 16'($random(seed));
	endtask

	task automatic end_of_test;
		$display("compares %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// cuts a hang short; well above the expected run length
	initial
	begin
		repeat (90000) @(posedge pclk);
		miscompares++;
		end_of_test();
	end

	initial
	begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
		// every strap setting; a foreign address must be refused first
		for (int k = 0; k < 4; k++)
		begin
			{addr_strap_high, addr_strap_low} <= 2'(k);
			ad = {`PSS_ADDR_BASE, 2'(k)};
			repeat (4) @(posedge pclk);
			op(S | P, {ad ^ 7'h03, 1'b0});
			`CHK("foreign ack", 1'b0, stat[1]);
			wr(`PSS_CMD_BLOCK);
			`CHK("mode", pss_pkg::MODE_BLOCK, read_mode);
			`CHK("busy", 1'b0, conv_busy);
		end
		// blocking reads: corner values, then prompt and late reads
		pres <= 16'h8001;
		temp <= 16'hFFFF;
		supp <= 16'h7FFF;
		rd(1);
		cmp(1, 1'b1);
		`CHK("long first", 1'b1, d > LONG);
		`CHK("sda freed", 1'b0, pss_i2c_if_inst.dev_sda_oe);
		`CHK("awake", 1'b0, asleep);
		rnd();
		rd(6);
		cmp(6, 1'b1);
		`CHK("short next", 1'b1, d > 0 && d < LONG);
		repeat (T_WAKE + 50) @(posedge pclk);
		`CHK("asleep", 1'b1, asleep);
		rnd();
		rd(1);
		cmp(1, 1'b1);
		`CHK("long again", 1'b1, d > LONG);
		`CHK("mode", pss_pkg::MODE_BLOCK, read_mode);
		// background conversion, read while it still runs
		rnd();
		wr(`PSS_CMD_START);
		`CHK("busy", 1'b1, conv_busy);
		`CHK("mode", pss_pkg::MODE_START, read_mode);
		rd(1);
		cmp(1, 1'b1);
		`CHK("stalled", 1'b1, d > 0);
		rd(2);
		cmp(2, 1'b0);
		`CHK("no stall", 0, d);
		// restart, let it finish, then read without a stall
		rnd();
		wr(`PSS_CMD_START);
		repeat (T_FIRST + 100) @(posedge pclk);
		rd(6);
		cmp(6, 1'b1);
		`CHK("pressure", {pres[15:1], 1'b0}, {got[1], got[0][7:1], 1'b0});
		`CHK("no stall", 0, d);
		// read abandoned mid-frame, bus flushed, then firmware reset
		op(S, {ad, 1'b1});
		op(R, 8'hFF);
		op(F, 8'h00);
		// the device sees the last falling clock a few cycles late
		repeat (4) @(posedge pclk);
		`CHK("flushed", 1'b0, pss_i2c_if_inst.dev_sda_oe);
		wr(`PSS_CMD_RESET);
		`CHK("mode", pss_pkg::MODE_NONE, read_mode);
		`CHK("flag", 1'b0, new_data_flag);
		`CHK("asleep", 1'b1, asleep);
		rd(2);
		`CHK("cleared", 16'h0000, {got[1], got[0]});
		`CHK("no stall", 0, d);
		// unmapped register answers zero with an error
		apb(8'h08, 1'b0, 32'h0, stat);
		`CHK("unmapped data", 32'h0, stat);
		`CHK("unmapped err", 1'b1, errq[0]);
		end_of_test();
	end
endmodule
